// ===== verilog/sweep_pkg.sv
// constants, register map and state codes of the sweep parameter block
// assumes a 16-bit configuration word port and one 100 MHz clock
package sweep_pkg;
    // widths of the stored fields
    localparam int FREQ_W    = 24;
    localparam int HALF_W    = 12;
    localparam int STEP_W    = 23;
    localparam int STEP_HI_W = 11;
    localparam int COUNT_W   = 12;
    localparam int INTV_W    = 11;
    localparam int WORD_W    = 16;
    localparam int ADDR_W    = 3;
    localparam int PRE_W     = 9;

    // register port addresses
    localparam logic [ADDR_W-1:0] ADDR_CONFIG  = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_LO = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_HI = 3'h4;

    // leading address bits of a configuration word
    localparam logic [3:0] CODE_START_LO = 4'hc;
    localparam logic [3:0] CODE_START_HI = 4'hd;
    localparam logic [3:0] CODE_STEP_LO  = 4'h2;
    localparam logic [3:0] CODE_STEP_HI  = 4'h3;
    localparam logic [3:0] CODE_COUNT    = 4'h1;
    localparam logic [1:0] CODE_INTERVAL = 2'h1;
    localparam logic [1:0] CODE_BURST    = 2'h2;

    // field positions inside a configuration word
    localparam int BIT_COUNT_BASE = 13;
    localparam int BIT_MULT_HI    = 12;
    localparam int BIT_MULT_LO    = 11;
    localparam int BIT_STEP_SIGN  = 11;

    // control register bits
    localparam int BIT_FULL_WIDTH = 11;
    localparam int BIT_CONTINUOUS = 7;
    localparam int BIT_TRIG_EXT   = 5;
    localparam logic [WORD_W-1:0] CONTROL_RESET = 16'h0080;
    localparam logic [WORD_W-1:0] CONTROL_MASK  = 16'h08a0;

    // time-base multiplier codes and prescaler terminal counts
    localparam logic [1:0] MULT_X1   = 2'h0;
    localparam logic [1:0] MULT_X5   = 2'h1;
    localparam logic [1:0] MULT_X100 = 2'h2;
    localparam logic [1:0] MULT_X500 = 2'h3;
    localparam logic [PRE_W-1:0] PRE_LAST_X1   = 9'h000;
    localparam logic [PRE_W-1:0] PRE_LAST_X5   = 9'h004;
    localparam logic [PRE_W-1:0] PRE_LAST_X100 = 9'h063;
    localparam logic [PRE_W-1:0] PRE_LAST_X500 = 9'h1f3;
    localparam logic [INTV_W-1:0] ELAPSED_MAX  = 11'h7ff;
    localparam logic [INTV_W:0]   ELAPSED_ONE  = 12'h001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } sweep_state_t;
endpackage : sweep_pkg

// ===== verilog/interval_if.sv
// carrier between the sweep sequencer and its base-interval timer
// assumes both ends share clk_in
`timescale 1ns/1ps
`default_nettype none
interface interval_if;
    import sweep_pkg::*;
    logic              restart;
    logic              by_clock;
    logic [1:0]        mult_sel;
    logic              tick;
    logic [INTV_W-1:0] elapsed;
    modport seq   (output restart, output by_clock, output mult_sel,
                   input tick, input elapsed);
    modport timer (input restart, input by_clock, input mult_sel,
                   output tick, output elapsed);
endinterface : interval_if
`default_nettype wire

// ===== verilog/interval_timer.sv
// base-interval timer: makes base ticks and counts them since restart
// assumes cycle_pulse_in is a one-cycle pulse per output cycle, same clock
`timescale 1ns/1ps
`default_nettype none
module interval_timer
    import sweep_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    input  wire logic  cycle_pulse_in,
    interval_if.timer  tif
);
    logic [PRE_W-1:0]  pre_reg;
    logic [PRE_W-1:0]  pre_last;
    logic [INTV_W-1:0] elapsed_reg;
    logic              base_tick;

    // multiplier code to prescaler terminal count
    always_comb begin
        case (tif.mult_sel)
            MULT_X1:   pre_last = PRE_LAST_X1;
            MULT_X5:   pre_last = PRE_LAST_X5;
            MULT_X100: pre_last = PRE_LAST_X100;
            MULT_X500: pre_last = PRE_LAST_X500;
            default:   pre_last = PRE_LAST_X1;
        endcase
    end

    // base interval is either scaled clock or one output waveform cycle
    assign base_tick = tif.by_clock ? (pre_reg == pre_last)
                                    : cycle_pulse_in;

    // prescaler, restarted with the interval so phases line up
    always_ff @(posedge clk_in) begin
        if (rst_in || tif.restart || !tif.by_clock) begin
            pre_reg <= '0;
        end else if (pre_reg == pre_last) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 9'h001;
        end
    end

    // elapsed base intervals; saturates so an idle wait cannot wrap
    always_ff @(posedge clk_in) begin
        if (rst_in || tif.restart) begin
            elapsed_reg <= '0;
        end else if (base_tick && elapsed_reg != ELAPSED_MAX) begin
            elapsed_reg <= elapsed_reg + 11'h001;
        end
    end

    assign tif.tick    = base_tick; // ungated: restart is built from it
    assign tif.elapsed = elapsed_reg;
endmodule : interval_timer
`default_nettype wire

// ===== verilog/sweep_param_regs.sv
// sweep parameter registers and the sweep sequencer behind them
// assumes a one-cycle strobe register port, ctrl_pin_in asynchronous,
// cycle_pulse_in from the oscillator logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module sweep_param_regs
    import sweep_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [WORD_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [WORD_W-1:0] rdata_out,
    input  wire logic              ctrl_pin_in,
    input  wire logic              cycle_pulse_in,
    output logic      [FREQ_W-1:0] freq_word_out,
    output logic                   midscale_out,
    output logic                   sweep_active_out,
    output logic                   step_pulse_out
);
    interval_if tif ();

    // stored parameters
    logic [HALF_W-1:0]    start_lo_reg;
    logic [HALF_W-1:0]    start_hi_reg;
    logic [HALF_W-1:0]    pend_lo_reg;
    logic                 pend_valid_reg;
    logic [HALF_W-1:0]    step_lo_reg;
    logic [STEP_HI_W-1:0] step_hi_reg;
    logic                 step_neg_reg;
    logic [COUNT_W-1:0]   count_reg;
    logic [INTV_W-1:0]    intv_len_reg;
    logic                 intv_by_clock_reg;
    logic [1:0]           intv_mult_reg;
    logic [INTV_W-1:0]    burst_len_reg;
    logic [WORD_W-1:0]    control_reg;

    // parameters captured when a sweep starts
    logic [STEP_W-1:0]    run_step_reg;
    logic                 run_neg_reg;
    logic [COUNT_W-1:0]   run_count_reg;
    logic [INTV_W-1:0]    run_intv_reg;
    logic [INTV_W-1:0]    run_burst_reg;
    logic                 run_by_clock_reg;
    logic [1:0]           run_mult_reg;
    logic                 run_burst_mode_reg;
    logic                 run_trig_ext_reg;

    // sequencer state
    sweep_state_t         state_reg;
    logic [FREQ_W-1:0]    freq_reg;
    logic [COUNT_W-1:0]   steps_done_reg;
    logic                 ctrl_meta_reg;
    logic                 ctrl_sync_reg;
    logic                 ctrl_prev_reg;
    logic                 midscale_reg;
    logic                 step_pulse_reg;
    logic [WORD_W-1:0]    rdata_reg;

    // decode helpers
    logic                 cfg_wr;
    logic [3:0]           code4;
    logic [HALF_W-1:0]    data12;
    logic                 full_width;
    logic                 ctrl_rise;
    logic                 interval_end;
    logic                 step_event;
    logic                 start_event;
    logic                 last_step;
    logic [FREQ_W-1:0]    step_ext;
    logic [FREQ_W-1:0]    freq_next;
    logic                 midscale_next;

    assign cfg_wr     = wr_in && (addr_in == ADDR_CONFIG);
    assign code4      = wdata_in[WORD_W-1 -: 4];
    assign data12     = wdata_in[HALF_W-1:0];
    assign full_width = control_reg[BIT_FULL_WIDTH];

    // start frequency halves; full-width mode parks the low half until
    // the high half arrives so the running word never shows a mix
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            start_lo_reg   <= '0;
            start_hi_reg   <= '0;
            pend_lo_reg    <= '0;
            pend_valid_reg <= 1'b0;
        end else if (cfg_wr && code4 == CODE_START_LO) begin
            if (full_width) begin
                pend_lo_reg    <= data12;
                pend_valid_reg <= 1'b1;
            end else begin
                start_lo_reg   <= data12;
            end
        end else if (cfg_wr && code4 == CODE_START_HI) begin
            start_hi_reg <= data12;
            if (full_width && pend_valid_reg) begin
                start_lo_reg   <= pend_lo_reg;
                pend_valid_reg <= 1'b0;
            end
        end
    end

    // frequency step and its direction
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            step_lo_reg  <= '0;
            step_hi_reg  <= '0;
            step_neg_reg <= 1'b0;
        end else if (cfg_wr && code4 == CODE_STEP_LO) begin
            step_lo_reg  <= data12;
        end else if (cfg_wr && code4 == CODE_STEP_HI) begin
            step_hi_reg  <= wdata_in[STEP_HI_W-1:0];
            step_neg_reg <= wdata_in[BIT_STEP_SIGN];
        end
    end

    // step count, interval and burst length
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_reg         <= '0;
            intv_len_reg      <= '0;
            intv_by_clock_reg <= 1'b0;
            intv_mult_reg     <= MULT_X1;
            burst_len_reg     <= '0;
        end else if (cfg_wr && code4 == CODE_COUNT) begin
            count_reg <= data12;
        end else if (cfg_wr && wdata_in[WORD_W-1 -: 2] == CODE_INTERVAL)
        begin
            intv_by_clock_reg <= wdata_in[BIT_COUNT_BASE];
            intv_mult_reg <= wdata_in[BIT_MULT_HI:BIT_MULT_LO];
            intv_len_reg  <= wdata_in[INTV_W-1:0];
        end else if (cfg_wr && wdata_in[WORD_W-1 -: 2] == CODE_BURST) begin
            // base and multiplier bits of this word are not kept at all
            burst_len_reg <= wdata_in[INTV_W-1:0];
        end
    end

    // control register, own address
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_in && addr_in == ADDR_CONTROL) begin
            control_reg <= wdata_in & CONTROL_MASK;
        end
    end

    // ctrl pin is asynchronous: two flops, then the edge detector
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_meta_reg <= 1'b0;
            ctrl_sync_reg <= 1'b0;
            ctrl_prev_reg <= 1'b0;
        end else begin
            ctrl_meta_reg <= ctrl_pin_in;
            ctrl_sync_reg <= ctrl_meta_reg;
            ctrl_prev_reg <= ctrl_sync_reg;
        end
    end

    assign ctrl_rise = ctrl_sync_reg && !ctrl_prev_reg;

    // an interval ends on the tick that completes its last base interval
    assign interval_end = tif.tick &&
        (({1'b0, tif.elapsed} + ELAPSED_ONE) >= {1'b0, run_intv_reg});

    // edges restart in internal mode, step in external mode
    assign start_event = ctrl_rise &&
        ((state_reg != ST_RUN) || !run_trig_ext_reg);
    assign step_event  = (state_reg == ST_RUN) && !start_event &&
        (run_trig_ext_reg ? ctrl_rise : interval_end);
    assign last_step   = (steps_done_reg == run_count_reg);

    // signed step applied modulo the accumulator width
    assign step_ext  = {1'b0, run_step_reg};
    assign freq_next = run_neg_reg ? (freq_reg - step_ext)
                                   : (freq_reg + step_ext);

    // timer follows the captured interval settings
    assign tif.restart  = start_event || step_event;
    assign tif.by_clock = run_by_clock_reg;
    assign tif.mult_sel = run_mult_reg;

    interval_timer u_timer (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .cycle_pulse_in (cycle_pulse_in),
        .tif            (tif)
    );

    // capture parameters at start so mid-sweep writes wait for the next
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            run_step_reg       <= '0;
            run_neg_reg        <= 1'b0;
            run_count_reg      <= '0;
            run_intv_reg       <= '0;
            run_burst_reg      <= '0;
            run_by_clock_reg   <= 1'b0;
            run_mult_reg       <= MULT_X1;
            run_burst_mode_reg <= 1'b0;
            run_trig_ext_reg   <= 1'b0;
        end else if (start_event) begin
            run_step_reg       <= {step_hi_reg, step_lo_reg};
            run_neg_reg        <= step_neg_reg;
            run_count_reg      <= count_reg;
            run_intv_reg       <= intv_len_reg;
            run_burst_reg      <= burst_len_reg;
            run_by_clock_reg   <= intv_by_clock_reg;
            run_mult_reg       <= intv_mult_reg;
            run_burst_mode_reg <= !control_reg[BIT_CONTINUOUS];
            run_trig_ext_reg   <= control_reg[BIT_TRIG_EXT];
        end
    end

    // sequencer: start frequency, then count steps up to the step count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg      <= ST_IDLE;
            freq_reg       <= '0;
            steps_done_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE, ST_DONE: begin
                    if (start_event) begin
                        state_reg      <= ST_RUN;
                        freq_reg <= {start_hi_reg, start_lo_reg};
                        steps_done_reg <= '0;
                    end
                end
                ST_RUN: begin
                    if (start_event) begin
                        freq_reg <= {start_hi_reg, start_lo_reg};
                        steps_done_reg <= '0;
                    end else if (step_event) begin
                        if (last_step) begin
                            state_reg <= ST_DONE;
                        end else begin
                            freq_reg <= freq_next;
                            steps_done_reg <= steps_done_reg + 12'h001;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // burst window: output until burst length, then midscale; outside a
    // sweep the output also rests at midscale
    assign midscale_next = (state_reg != ST_RUN) ||
        (run_burst_mode_reg && (tif.elapsed >= run_burst_reg));

    // registered data outputs, one cycle behind the sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            midscale_reg   <= 1'b1;
            step_pulse_reg <= 1'b0;
        end else begin
            midscale_reg   <= midscale_next;
            step_pulse_reg <= step_event && !last_step;
        end
    end

    // read port; unmapped and write-only addresses read zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_reg <= '0;
        end else if (rd_in) begin
            case (addr_in)
                ADDR_CONTROL: rdata_reg <= control_reg;
                ADDR_STATUS:  rdata_reg <= {state_reg == ST_RUN,
                                            state_reg == ST_DONE,
                                            midscale_reg,
                                            pend_valid_reg,
                                            steps_done_reg};
                ADDR_FREQ_LO: rdata_reg <= freq_reg[WORD_W-1:0];
                ADDR_FREQ_HI: rdata_reg <= {8'h00,
                                            freq_reg[FREQ_W-1:WORD_W]};
                default:      rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata_out        = rdata_reg;
    assign freq_word_out    = freq_reg;
    assign midscale_out     = midscale_reg;
    assign sweep_active_out = (state_reg == ST_RUN);
    assign step_pulse_out   = step_pulse_reg;
endmodule : sweep_param_regs
`default_nettype wire

// ===== tb/sweep_param_regs_chk.sv
// port-level assertions for the sweep parameter block
// assumes reset is held at least two clocks whenever it is raised
`timescale 1ns/1ps
`default_nettype none
module sweep_param_regs_chk
    import sweep_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [WORD_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [WORD_W-1:0] rdata_out,
    input wire logic              ctrl_pin_in,
    input wire logic              cycle_pulse_in,
    input wire logic [FREQ_W-1:0] freq_word_out,
    input wire logic              midscale_out,
    input wire logic              sweep_active_out,
    input wire logic              step_pulse_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // pin rise that stays up past the two-stage synchroniser
    sequence s_pin_rise;
        $rose(ctrl_pin_in) ##1 ctrl_pin_in [*2];
    endsequence
    // two idle cycles in a row, so the stop transient is over
    sequence s_idle_two;
        !sweep_active_out ##1 !sweep_active_out;
    endsequence

    a_rdata_quiet: assert property (
        !$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (
        $past(rd_in) && $past(addr_in) > ADDR_FREQ_HI |-> rdata_out == 16'h0)
        else $error("unmapped read returned data");
    a_control_bits: assert property (
        $past(rd_in) && $past(addr_in) == ADDR_CONTROL
        |-> (rdata_out & ~CONTROL_MASK) == 16'h0000)
        else $error("undefined control bits read as one");
    a_freq_low_read: assert property (
        $past(rd_in) && $past(addr_in) == ADDR_FREQ_LO
        |-> rdata_out == 16'($past(freq_word_out)))
        else $error("low frequency read mismatch");
    a_freq_high_read: assert property (
        $past(rd_in) && $past(addr_in) == ADDR_FREQ_HI
        |-> rdata_out == 16'($past(freq_word_out) >> 16))
        else $error("high frequency read mismatch");
    a_idle_midscale: assert property (
        s_idle_two |-> midscale_out)
        else $error("output not at midscale while idle");
    a_idle_holds: assert property (
        s_idle_two ##0 !$past(rst_in) |-> $stable(freq_word_out))
        else $error("frequency moved while idle");
    a_start_reach: assert property (
        s_pin_rise |-> ##[0:3] sweep_active_out)
        else $error("pin rise did not start a sweep");
    a_pulse_single: assert property (
        step_pulse_out |=> !step_pulse_out)
        else $error("step pulse longer than one cycle");
    a_pulse_in_sweep: assert property (
        step_pulse_out |-> $past(sweep_active_out))
        else $error("step pulse outside a sweep");
endmodule : sweep_param_regs_chk

bind sweep_param_regs sweep_param_regs_chk sweep_param_regs_chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ctrl_pin_in(ctrl_pin_in),
    .cycle_pulse_in(cycle_pulse_in), .freq_word_out(freq_word_out),
    .midscale_out(midscale_out), .sweep_active_out(sweep_active_out),
    .step_pulse_out(step_pulse_out)
);
`default_nettype wire

// ===== tb/sweep_host.sv
// host model: register port writer and reader, control pin driver
// assumes the block shares its clock and answers reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module sweep_host
    import sweep_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [WORD_W-1:0] rdata_in,
    output var  logic [ADDR_W-1:0] addr_out,
    output var  logic [WORD_W-1:0] wdata_out,
    output var  logic              wr_out,
    output var  logic              rd_out,
    output var  logic              pin_out
);
    // quiet bus and low pin from time zero
    initial begin
        addr_out  = 3'h0;
        wdata_out = 16'h0000;
        wr_out    = 1'h0;
        rd_out    = 1'h0;
        pin_out   = 1'h0;
    end

    // one-cycle write; callers send the low start half first
    // and keep count and interval at two or more
    task put(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'h1;
        @(posedge clk_in);
        wr_out    <= 1'h0;
        wdata_out <= ~d; // stale data must not look valid
    endtask : put

    // one-cycle read; data taken in the cycle after the strobe
    task get(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'h1;
        @(posedge clk_in);
        rd_out   <= 1'h0;
        #1;
        d = rdata_in;
    endtask : get

    // pin high for n clocks; the rise starts or steps a sweep
    task pulse(input int n);
        @(posedge clk_in);
        pin_out <= 1'h1;
        repeat (n) @(posedge clk_in);
        pin_out <= 1'h0;
    endtask : pulse
endmodule : sweep_host
`default_nettype wire

// ===== tb/sweep_param_regs_tb.sv
// self-checking bench for the sweep parameter block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module sweep_param_regs_tb
    import sweep_pkg::*;
;
    logic              clk_in;
    logic              rst_in;
    logic [ADDR_W-1:0] addr_in;
    logic [WORD_W-1:0] wdata_in;
    logic              wr_in;
    logic              rd_in;
    logic [WORD_W-1:0] rdata_out;
    logic              ctrl_pin_in;
    logic              cycle_pulse_in;
    logic [FREQ_W-1:0] freq_word_out;
    logic              midscale_out;
    logic              sweep_active_out;
    logic              step_pulse_out;
    logic [WORD_W-1:0] rd_val;
    int                n_errors;
    int                compares;
    int                ticks;
    int                burst_ms;
    int                mult_tab [4] = '{1, 5, 100, 500};

    sweep_param_regs sweep_param_regs_i (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .ctrl_pin_in(ctrl_pin_in),
        .cycle_pulse_in(cycle_pulse_in), .freq_word_out(freq_word_out),
        .midscale_out(midscale_out), .sweep_active_out(sweep_active_out),
        .step_pulse_out(step_pulse_out));
    sweep_host sweep_host_i (.clk_in(clk_in), .rdata_in(rdata_out),
        .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
        .rd_out(rd_in), .pin_out(ctrl_pin_in));

    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    // output-cycle pulse every fourth clock, plus the hang watchdog
    always @(posedge clk_in) begin
        ticks          <= ticks + 1;
        cycle_pulse_in <= (ticks % 4 == 3);
        if (ticks == 20000) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: run hung", $time);
            conclude();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // start a sweep, follow it to the end, then read back the result
    task sweep(input logic [23:0] s, input logic [23:0] d, input int n,
               input int per, input int tol);
        logic [23:0] exp_f;
        int          cyc;
        int          steps;
        int          pulses;
        fork
            sweep_host_i.pulse(4);
        join_none
        for (int k = 0; k < 12 && sweep_active_out !== 1'h1; k++) begin
            @(posedge clk_in);
            #1;
        end
        check(32'(freq_word_out), 32'(s));
        exp_f    = s;
        cyc      = 0;
        steps    = 0;
        pulses   = 0;
        burst_ms = 0;
        while (sweep_active_out === 1'h1 && cyc < 8000) begin
            cyc      = cyc + 1;
            burst_ms = burst_ms + int'(midscale_out === 1'h1);
            @(posedge clk_in);
            #1;
            pulses   = pulses + int'(step_pulse_out === 1'h1);
            if (sweep_active_out === 1'h1 && freq_word_out !== exp_f) begin
                exp_f = exp_f + d;
                steps = steps + 1;
                check(32'(freq_word_out), 32'(exp_f));
            end
        end
        check(32'(steps), 32'(n));
        check(32'(pulses), 32'(n));
        check(32'(cyc >= per * (n + 1) - tol && cyc <= per * (n + 1) + tol),
              32'h1);
        sweep_host_i.get(ADDR_STATUS, rd_val);
        check(32'(rd_val & 16'hefff), 32'h6000 | 32'(n));
        sweep_host_i.get(ADDR_FREQ_HI, rd_val);
        check(32'(rd_val), 32'(exp_f[23:16]));
        sweep_host_i.get(ADDR_FREQ_LO, rd_val);
        check(32'(rd_val), 32'(exp_f[15:0]));
        $display("sweep from %h done", s);
    endtask : sweep

    task t_reset;
        sweep_host_i.get(ADDR_CONTROL, rd_val);
        check(32'(rd_val), 32'(CONTROL_RESET));
        sweep_host_i.put(3'h5, 16'hffff);
        sweep_host_i.get(3'h6, rd_val);
        check(32'(rd_val), 32'h0000);
        sweep_host_i.get(ADDR_STATUS, rd_val);
        check(32'(rd_val), 32'h2000);
        $display("reset test done");
    endtask : t_reset

    // every multiplier, a falling wrap, then the output-cycle base
    task t_sweeps;
        sweep_host_i.put(ADDR_CONTROL, 16'h0880);
        sweep_host_i.put(ADDR_CONFIG, 16'hc123);
        sweep_host_i.put(ADDR_CONFIG, 16'hd456);
        sweep_host_i.put(ADDR_CONFIG, 16'h2010);
        sweep_host_i.put(ADDR_CONFIG, 16'h3001);
        sweep_host_i.put(ADDR_CONFIG, 16'h1002);
        sweep_host_i.put(ADDR_CONFIG, 16'h0abc); // no field selected
        for (int m = 0; m < 4; m++) begin
            sweep_host_i.put(ADDR_CONFIG, 16'h6002 | 16'(m << 11));
            sweep(24'h456123, 24'h001010, 2, 2 * mult_tab[m], 0);
        end
        sweep_host_i.put(ADDR_CONFIG, 16'hc005);
        sweep_host_i.put(ADDR_CONFIG, 16'hd000);
        sweep_host_i.put(ADDR_CONFIG, 16'h3800); // falling
        sweep_host_i.put(ADDR_CONFIG, 16'h6002);
        sweep(24'h000005, 24'hfffff0, 2, 2, 0); // wraps below zero
        sweep_host_i.put(ADDR_CONFIG, 16'h4002);
        sweep(24'h000005, 24'hfffff0, 2, 8, 4); // output cycles
    endtask : t_sweeps

    // low half parks under full width, then halves apart
    task t_halves;
        sweep_host_i.put(ADDR_CONFIG, 16'h6002);
        sweep_host_i.put(ADDR_CONFIG, 16'hc777);
        sweep(24'h000005, 24'hfffff0, 2, 2, 0); // still parked
        sweep_host_i.put(ADDR_CONFIG, 16'hd0ab);
        sweep_host_i.put(ADDR_CONTROL, 16'h0080);
        sweep_host_i.put(ADDR_CONFIG, 16'hc321);
        sweep(24'h0ab321, 24'hfffff0, 2, 2, 0);
    endtask : t_halves

    // burst with its own base and scale bits set contrary
    task t_burst;
        sweep_host_i.put(ADDR_CONTROL, 16'h0000);
        sweep_host_i.put(ADDR_CONFIG, 16'h6004);
        sweep_host_i.put(ADDR_CONFIG, 16'h9801);
        sweep(24'h0ab321, 24'hfffff0, 2, 4, 0);
        check(32'(burst_ms >= 3 && burst_ms <= 9), 32'h1);
    endtask : t_burst

    // pin rises make each step instead of the interval timer
    task t_external;
        sweep_host_i.put(ADDR_CONTROL, 16'h00a0);
        sweep_host_i.pulse(4);
        repeat (4) @(posedge clk_in);
        #1;
        check(32'(freq_word_out), 32'h0ab321);
        sweep_host_i.pulse(4);
        repeat (4) @(posedge clk_in);
        #1;
        check(32'(freq_word_out), 32'h0ab311);
        $display("external test done");
    endtask : t_external

    initial begin
        n_errors       = 0;
        compares       = 0;
        ticks          = 0;
        burst_ms       = 0;
        cycle_pulse_in = 1'h0;
        rst_in         = 1'h1;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_sweeps();
        t_halves();
        t_burst();
        t_external();
        conclude();
    end
endmodule : sweep_param_regs_tb
`default_nettype wire
